// ===== inc/dct_defs.vh
// Register map, field positions, reset values and codes of the dual channel timer
`ifndef DCT_DEFS_VH
`define DCT_DEFS_VH

`define DCT_OFS_START   8'h00
`define DCT_OFS_FUNC    8'h04
`define DCT_OFS_IRQST   8'h08
`define DCT_OFS_IRQMSK  8'h0c
`define DCT_CH0_BASE    8'h20
`define DCT_CH1_BASE    8'h40

`define DCT_IDX_CTRL    3'h0
`define DCT_IDX_CNT     3'h1
`define DCT_IDX_GRA     3'h2
`define DCT_IDX_LAST    3'h5

`define DCT_START_RUN   0
`define DCT_START_SEL   2
`define DCT_FUNC_CMD    0
`define DCT_FUNC_OLSP   2
`define DCT_FUNC_OLSN   3
`define DCT_CTRL_CLR    0
`define DCT_CTRL_CKS    3
`define DCT_CTRL_CAP    6
`define DCT_CTRL_W      10
`define DCT_EV_W        10

`define DCT_START_RST   4'h0
`define DCT_FUNC_RST    4'h0
`define DCT_CTRL_RST    10'h000
`define DCT_CNT_CLEAR   16'h0000
`define DCT_CNT_MAX     16'hffff

`define DCT_CLR_GRA     3'b001
`define DCT_CLR_GRB     3'b010
`define DCT_CLR_SYNC    3'b011
`define DCT_CLR_GRC     3'b101
`define DCT_CLR_GRD     3'b110
`define DCT_CMD_TIMER   2'b00

`endif

// ===== verilog/dct_timer.v
// Dual channel capture/compare/PWM timer with APB register access
//
// Behaviour
// RL1 - With stop-on-match select 0, a written run bit 0 is ignored.
// RL2 - Stop-on-match select must be 1 before run bit 0; same write does not stop.
// RL3 - Software stop keeps pin levels; PWM modes drive the output-level select levels.
// RL4 - Auto stop at match A keeps post-match levels; PWM modes drive selected levels.
// RL5 - Counter write coinciding with hardware clear is lost; counter becomes 0000h.
// RL6 - Clear source 001/010/101/110 clears on A/B/C/D events, 011 follows other channel.
// RL7 - Counter read right after a write may show the old value.
// RL8 - Status read right after a write may show the old value.
// RL9 - Count source 111b needs the fast oscillator above the CPU clock.
// RL10 - Change count source only after stopping the channel.
// RL11 - Wait two base clock cycles before turning off the 40 MHz oscillator.
// RL12 - From fast to 40 MHz source, wait two fast cycles before oscillator off.
// RL13 - From fast to another source, wait one fast plus one 40 MHz cycle.
// RL14 - Capture input pulses last at least three operating clock cycles.
// RL15 - Capture stores the counter two to three cycles after the pin edge.
// RL16 - Enter reset-synchronous PWM: stop channel 0, mode 00b, then 01b, reprogram.
// RL17 - For motor control keep both output-level select bits equal.
// RL18 - Start register is written whole, never read-modify-write.
`timescale 1ns/1ns
`include "dct_defs.vh"

module dct_timer
(
	input  wire        ref_clk,
	input  wire        reset,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [7:0]  srcTick,
	input  wire [7:0]  tioIn,
	output wire [7:0]  tioOut,
	output wire [7:0]  tioOe,
	output wire        irq
);

	reg  [1:0]              runR;
	reg  [1:0]              cselR;
	reg  [1:0]              cmdR;
	reg                     olsPosR;
	reg                     olsNegR;
	reg  [`DCT_EV_W-1:0]    irqStR;
	reg  [`DCT_EV_W-1:0]    irqMskR;
	reg  [31:0]             prdataR;
	reg                     validR;
	reg  [31:0]             rdMux;
	reg                     mapped;
	wire                    apbWr;
	wire                    apbRd;
	wire [1:0]              ownClrW;
	wire [1:0]              stopW;
	wire [1:0]              chHitW;
	wire [63:0]             chRdW;
	wire [`DCT_EV_W-1:0]    evW;
	wire                    pwmMode;
	integer                 i;

	// Zero wait APB: read data is latched in setup, so pready rises in the first access cycle
	assign pready  = ce & validR;
	assign prdata  = prdataR;
	assign pslverr = psel & penable & pready & ~mapped;
	assign apbWr   = psel & penable & pready & pwrite & mapped;
	assign apbRd   = psel & penable & pready & ~pwrite & mapped;
	assign irq     = |(irqStR & irqMskR);
	assign pwmMode = (cmdR != `DCT_CMD_TIMER);

	always @*
	begin
		rdMux  = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`DCT_OFS_START:  rdMux = {28'h0000000, cselR, runR};
			`DCT_OFS_FUNC:   rdMux = {28'h0000000, olsNegR, olsPosR, cmdR};
			`DCT_OFS_IRQST:  rdMux = {22'h000000, irqStR};
			`DCT_OFS_IRQMSK: rdMux = {22'h000000, irqMskR};
			default:
			begin
				mapped = |chHitW;
				rdMux  = chRdW[31:0] | chRdW[63:32];
			end
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			prdataR <= 32'h00000000;
			validR  <= 1'b0;
		end
		else if (ce)
		begin
			validR  <= psel & ~(penable & validR);
			prdataR <= rdMux;
		end
	end

	// Start register and function control
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			{cselR, runR}             <= `DCT_START_RST;
			{olsNegR, olsPosR, cmdR}  <= `DCT_FUNC_RST;
		end
		else if (ce)
		begin
			for (i = 0; i < 2; i = i + 1)
			begin
				if (apbWr && paddr == `DCT_OFS_START && pwdata[`DCT_START_RUN + i])
					runR[i] <= 1'b1;
				else if (apbWr && paddr == `DCT_OFS_START && cselR[i]) // [RL2]
					runR[i] <= 1'b0; // [RL3]
				else if (stopW[i])
					runR[i] <= 1'b0; // [RL4]
				// Old select decides, so a write of 0 with select 0 leaves the bit alone [RL1]
			end
			if (apbWr && paddr == `DCT_OFS_START)
				cselR <= pwdata[`DCT_START_SEL +: 2]; // [RL18]
			if (apbWr && paddr == `DCT_OFS_FUNC)
			begin
				cmdR    <= pwdata[`DCT_FUNC_CMD +: 2]; // [RL16]
				olsPosR <= pwdata[`DCT_FUNC_OLSP];
				olsNegR <= pwdata[`DCT_FUNC_OLSN];
			end
		end
	end

	// Sticky events; a read clears only the bits it returned, so a new event is never lost
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			irqStR  <= {`DCT_EV_W{1'b0}};
			irqMskR <= {`DCT_EV_W{1'b0}};
		end
		else if (ce)
		begin
			if (apbRd && paddr == `DCT_OFS_IRQST)
				irqStR <= (irqStR & ~prdataR[`DCT_EV_W-1:0]) | evW; // [RL8]
			else
				irqStR <= irqStR | evW;
			if (apbWr && paddr == `DCT_OFS_IRQMSK)
				irqMskR <= pwdata[`DCT_EV_W-1:0];
		end
	end

	genvar gi;
	genvar gj;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : gCh
			reg  [`DCT_CTRL_W-1:0] ctrlR;
			reg  [15:0]            cntR;
			reg  [3:0]             pinR;
			reg  [3:0]             outR;
			reg  [3:0]             capD1R;
			reg  [3:0]             capD2R;
			wire [7:0]             baseW;
			wire [2:0]             idxW;
			wire                   hit;
			wire                   wrCh;
			wire                   tick;
			wire                   counting;
			wire [3:0]             capEn;
			wire [2:0]             clrSel;
			wire [3:0]             match;
			wire [3:0]             cap;
			wire [3:0]             ev;
			wire [63:0]            grW;
			wire                   ownClr;
			wire                   hwClr;
			wire                   ovf;
			wire                   lvl;
			reg  [31:0]            rdCh;

			assign baseW    = (gi == 0) ? `DCT_CH0_BASE : `DCT_CH1_BASE;
			assign idxW     = paddr[4:2];
			assign hit      = (paddr[7:5] == baseW[7:5]) && (idxW <= `DCT_IDX_LAST)
			                  && (paddr[1:0] == 2'b00);
			assign wrCh     = apbWr & hit;
			// Count source is a tick enable; the select must only change while stopped [RL10]
			assign tick     = srcTick[ctrlR[`DCT_CTRL_CKS +: 3]]; // [RL9]
			assign counting = runR[gi] & tick;
			assign capEn    = ctrlR[`DCT_CTRL_CAP +: 4];
			assign clrSel   = ctrlR[`DCT_CTRL_CLR +: 3];
			assign ev       = match | cap;

			for (gj = 0; gj < 4; gj = gj + 1)
			begin : gGr
				reg [15:0] grR;
				assign grW[16*gj +: 16] = grR;
				assign match[gj] = ~capEn[gj] & counting & (cntR == grR);
				// Edge seen one edge after the pin, stored at the next: two cycles [RL15]
				assign cap[gj]   = capEn[gj] & capD1R[gj] & ~capD2R[gj]; // [RL14]
				always @(posedge ref_clk)
				begin
					if (reset)
						grR <= `DCT_CNT_CLEAR;
					else if (ce)
					begin
						if (cap[gj])
							grR <= cntR;
						else if (wrCh && idxW == `DCT_IDX_GRA + gj)
							grR <= pwdata[15:0];
					end
				end
			end

			assign ownClr = (clrSel == `DCT_CLR_GRA && ev[0]) || (clrSel == `DCT_CLR_GRB && ev[1])
			             || (clrSel == `DCT_CLR_GRC && ev[2]) || (clrSel == `DCT_CLR_GRD && ev[3]);
			// Sync clear follows only the partner's own source, which avoids a loop
			assign hwClr  = ownClr | ((clrSel == `DCT_CLR_SYNC) & ownClrW[1-gi]); // [RL6]
			assign ovf    = counting & (cntR == `DCT_CNT_MAX) & ~hwClr;
			assign lvl    = (gi == 0) ? olsPosR : olsNegR; // [RL17]

			assign ownClrW[gi]        = ownClr;
			assign stopW[gi]          = ~cselR[gi] & match[0]; // [RL4]
			assign chHitW[gi]         = hit;
			assign chRdW[32*gi +: 32] = hit ? rdCh : 32'h00000000;
			assign evW[5*gi +: 5]     = {ovf, ev};
			assign tioOut[4*gi +: 4]  = outR;
			assign tioOe[4*gi +: 4]   = ~capEn;

			always @*
			begin
				rdCh = 32'h00000000;
				case (idxW)
					`DCT_IDX_CTRL: rdCh = {22'h000000, ctrlR};
					`DCT_IDX_CNT:  rdCh = {16'h0000, cntR}; // [RL7]
					3'h2:          rdCh = {16'h0000, grW[15:0]};
					3'h3:          rdCh = {16'h0000, grW[31:16]};
					3'h4:          rdCh = {16'h0000, grW[47:32]};
					3'h5:          rdCh = {16'h0000, grW[63:48]};
					default:       rdCh = 32'h00000000;
				endcase
			end

			always @(posedge ref_clk)
			begin
				if (reset)
				begin
					ctrlR  <= `DCT_CTRL_RST;
					cntR   <= `DCT_CNT_CLEAR;
					pinR   <= 4'h0;
					outR   <= 4'h0;
					capD1R <= 4'h0;
					capD2R <= 4'h0;
				end
				else if (ce)
				begin
					capD1R <= tioIn[4*gi +: 4];
					capD2R <= capD1R;
					pinR   <= pinR ^ match;
					// Stopped in a PWM mode the pins show the chosen idle level [RL3]
					if (pwmMode && !runR[gi])
						outR <= {4{lvl}};
					else
						outR <= pinR; // [RL4]
					if (hwClr)
						cntR <= `DCT_CNT_CLEAR; // [RL5]
					else if (wrCh && idxW == `DCT_IDX_CNT)
						cntR <= pwdata[15:0];
					else if (counting)
						cntR <= cntR + 16'h0001;
					if (wrCh && idxW == `DCT_IDX_CTRL)
						ctrlR <= pwdata[`DCT_CTRL_W-1:0];
				end
			end
		end
	endgenerate

endmodule

// ===== tb/dct_props.sv
// Port assertions for the dual channel timer
`timescale 1ns/1ns
module dct_props
(
	input logic        ref_clk,
	input logic        reset,
	input logic        ce,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic [7:0]  srcTick,
	input logic [7:0]  tioOut,
	input logic [7:0]  tioOe,
	input logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Two register stages sit between a tick and the pins, so four quiet cycles suffice
	sequence quiet4;
		(srcTick == 8'h00 && !psel) [*4];
	endsequence
	a_ready_first: assert property (psel && !penable && ce |=> pready) else $error("late ready");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held");
	a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_refused_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read");
	a_frozen_idle: assert property (!ce |-> !pready) else $error("ready while frozen");
	a_reset_levels: assert property ($fell(reset) |-> !irq && tioOut == 8'h00 && tioOe == 8'hff)
		else $error("bad levels after reset");
	a_pins_hold: assert property (quiet4 |=> $stable(tioOut))
		else $error("pins moved without a tick");
endmodule
bind dct_timer dct_props dct_props_i (.*);

// ===== tb/dct_pin_model.sv
// Far-side driver of the timer capture pins
`timescale 1ns/1ns
module dct_pin_model
(
	input  logic       ref_clk,
	output logic [7:0] tioIn
);
	initial tioIn = 8'h00;
	// Three clocks is the shortest pulse allowed on a capture pin; the capture logic catches a one-clock pulse
	task automatic pulse(input int b);
		tioIn[b] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		tioIn[b] <= 1'b0;
	endtask
endmodule

// ===== tb/dct_timer_tb_top.sv
// Self-checking bench for the dual channel timer
`timescale 1ns/1ns
module dct_timer_tb_top;
	logic        ref_clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, irq, e;
	logic [7:0]  paddr = 8'h00, srcTick = 8'h00, tioIn, tioOut, tioOe;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int          errTotal = 0, checks = 0;
	dct_timer dct_timer_i (.*);
	dct_pin_model dct_pin_model_i (.*);
	initial forever #4 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x)
		begin
			errTotal++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Ready is looked at mid-cycle, so the completing rising edge is the one after it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic t);
		logic ok;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		srcTick <= {7'h00, t};
		ok = 1'b0;
		for (int n = 0; n < 20 && ok !== 1'b1; n++)
		begin
			@(negedge ref_clk);
			ok = pready;
		end
		q = prdata;
		e = pslverr;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		srcTick <= 8'h00;
		chk({31'h0, ok}, 32'h1);
		if (ok !== 1'b1)
			giveVerdict;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 1'b0);
		chk(q, x);
	endtask
	task automatic sStartStop;
		rd(8'h00, 32'h0);
		chk({24'h0, tioOe}, 32'hff);
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h1);
		wr(8'h00, 32'h4);
		rd(8'h00, 32'h5);
		wr(8'h00, 32'h4);
		rd(8'h00, 32'h4);
	endtask
	// Match at 3 with clear on A: six ticks leave 2, then a write loses to the clear
	task automatic sCountClear;
		wr(8'h20, 32'h1);
		wr(8'h28, 32'h3);
		wr(8'h00, 32'h5);
		@(posedge ref_clk);
		srcTick <= 8'h01;
		repeat (6) @(posedge ref_clk);
		srcTick <= 8'h00;
		rd(8'h24, 32'h2);
		#1 chk({31'h0, irq}, 32'h0);
		wr(8'h0c, 32'h1);
		#1 chk({31'h0, irq}, 32'h1);
		rd(8'h08, 32'hf);
		#1 chk({31'h0, irq}, 32'h0);
		wr(8'h24, 32'h3);
		apb(1'b1, 8'h24, 32'h9, 1'b1);
		rd(8'h24, 32'h0);
		wr(8'h00, 32'h4);
	endtask
	task automatic sCapture;
		wr(8'h20, 32'h40);
		wr(8'h24, 32'h7);
		@(posedge ref_clk);
		dct_pin_model_i.pulse(0);
		rd(8'h28, 32'h7);
		chk({24'h0, tioOe}, 32'hfe);
		apb(1'b0, 8'h1c, 32'h0, 1'b0);
		chk({q[31:1], e}, 32'h1);
		ce <= 1'b0;
		repeat (2) @(posedge ref_clk);
		ce <= 1'b1;
	endtask
	// Count sources are plain ticks here, no oscillator is ever turned off
	task automatic sPwm;
		wr(8'h00, 32'h4);
		wr(8'h04, 32'h0);
		wr(8'h04, 32'hd);
		repeat (2) @(negedge ref_clk);
		chk({24'h0, tioOut}, 32'hff);
		wr(8'h04, 32'h0);
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		sStartStop;
		sCountClear;
		sCapture;
		sPwm;
		giveVerdict;
	end
endmodule
